// ---- design/clk_source_select.sv ----
// System clock source selector with start-up counter and fail monitor.
// Assumes oscillator inputs from pins; registers on AXI4-Lite.
//
// Functional notes
// - Eight source modes from fixed configuration field
// - Frequency field picks rate, resets to 110
// - Bit 3 shows external source running
// - Bit 2 shows high-frequency oscillator stable
// - Bit 1 shows low-frequency oscillator stable
// - Bit 0 selects internal oscillator when set
// - Running bit resets low with fail-safe, or with two-speed in crystal modes
// - Crystal modes count 1024 oscillations first
// - Execution held while start-up counter runs
// - Stabilisation delay on every external/internal switch
// - Driven clock mode skips start-up counter
// - Driven mode frees clock-out pin as I/O
// - Static logic holds state when clock stops
// - Gain output follows crystal mode
// - Quarter clock out in RC/internal-out modes
// - Lost external clock falls back internally
// - Fail flag sticky until software clears
//
// Chosen here: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ns
module clk_source_select
  import clk_sel_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [2:0] clkModeCfg,
  input wire logic twoSpeedEn,
  input wire logic failSafeEn,
  input wire logic wakeUp,
  input wire logic clockInPin,
  input wire logic hfOscIn,
  input wire logic lfOscIn,
  output logic sysClkEn,
  output logic execHold,
  output logic [1:0] gainSel,
  output logic clockOutPin,
  output logic clockOutOe,
  output logic clockInIsIo,
  output logic clockOutIsIo,
  output logic irq,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic isCrystal(input logic [2:0] m);
    isCrystal = (m == LOW_POWER_CRYSTAL_MODE) ||
                (m == MEDIUM_GAIN_CRYSTAL_MODE) ||
                (m == HIGH_GAIN_CRYSTAL_MODE);
  endfunction : isCrystal

  function automatic logic isInternal(input logic [2:0] m);
    isInternal = (m == INTERNAL_OSC_ALL_PINS_IO_MODE) ||
                 (m == INTERNAL_OSC_CLOCK_OUT_MODE);
  endfunction : isInternal

  function automatic pin_use_s pinUse(input logic [2:0] m);
    pinUse = '0;
    case (m)
      DRIVEN_CLOCK_INPUT_MODE: pinUse.outIsIo = 1'b1;
      RESISTOR_CAPACITOR_OSC_MODE: pinUse.outQuarter = 1'b1;
      RESISTOR_CAPACITOR_IO_MODE: pinUse.outIsIo = 1'b1;
      INTERNAL_OSC_CLOCK_OUT_MODE: begin
        pinUse.outQuarter = 1'b1;
        pinUse.inIsIo = 1'b1;
      end
      INTERNAL_OSC_ALL_PINS_IO_MODE: begin
        pinUse.inIsIo = 1'b1;
        pinUse.outIsIo = 1'b1;
      end
      default: pinUse = '0;
    endcase
  endfunction : pinUse

  // ----------------------------------------
  // Pin synchronisers and edge detect
  // ----------------------------------------
  logic [2:0] syncA_ff;
  logic [2:0] syncB_ff;
  logic [2:0] syncC_ff;
  logic [2:0] rise;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      syncA_ff <= '0;
      syncB_ff <= '0;
      syncC_ff <= '0;
    end else begin
      syncA_ff <= {lfOscIn, hfOscIn, clockInPin};
      syncB_ff <= syncA_ff;
      syncC_ff <= syncB_ff;
    end
  end
  assign rise = syncB_ff & ~syncC_ff;

  logic [2:0] modeCfg_ff;
  logic twoSpeed_ff;
  logic failSafe_ff;
  logic cfgDone_ff;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      modeCfg_ff <= '0;
      twoSpeed_ff <= 1'b0;
      failSafe_ff <= 1'b0;
      cfgDone_ff <= 1'b0;
    end else if (!cfgDone_ff) begin
      modeCfg_ff <= clkModeCfg;
      twoSpeed_ff <= twoSpeedEn;
      failSafe_ff <= failSafeEn;
      cfgDone_ff <= 1'b1;
    end
  end

  // ----------------------------------------
  // Register state
  // ----------------------------------------
  logic [2:0] freqSel_ff;
  logic sysSel_ff;
  logic failFlag_ff;
  logic failMask_ff;
  logic failEvent;
  logic extRun_ff;
  logic hfStable_ff;
  logic lfStable_ff;

  // ----------------------------------------
  // Oscillator stability counters
  // ----------------------------------------
  logic [CNT_W-1:0] hfWarm_ff;
  logic [CNT_W-1:0] lfWarm_ff;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hfWarm_ff <= '0;
      hfStable_ff <= 1'b0;
    end else if (rise[1] && !hfStable_ff) begin
      hfWarm_ff <= hfWarm_ff + 1'b1;
      hfStable_ff <= (hfWarm_ff == CNT_W'(HF_WARM_CYCLES - 1));
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lfWarm_ff <= '0;
      lfStable_ff <= 1'b0;
    end else if (rise[2] && !lfStable_ff) begin
      lfWarm_ff <= lfWarm_ff + 1'b1;
      lfStable_ff <= (lfWarm_ff == CNT_W'(LF_WARM_CYCLES - 1));
    end
  end

  // ----------------------------------------
  // Source switch state machine
  // ----------------------------------------
  typedef enum logic [2:0] {
    ST_CFG = 3'b000,
    ST_START = 3'b001,
    ST_EXT = 3'b010,
    ST_INT = 3'b011,
    ST_SW_OLD = 3'b100,
    ST_SW_NEW = 3'b101
  } sw_state_e;

  sw_state_e state_ff;
  logic [CNT_W-1:0] oscCnt_ff;
  logic [CNT_W-1:0] failCnt_ff;
  logic toExt_ff;
  logic wantInt;
  logic newEdge;
  logic oldEdge;
  logic intEdge;
  assign wantInt = sysSel_ff || isInternal(modeCfg_ff) || failFlag_ff;
  assign intEdge = (freqSel_ff == FREQ_LF) ? rise[2] : rise[1];
  assign newEdge = toExt_ff ? rise[0] : intEdge;
  assign oldEdge = toExt_ff ? intEdge : rise[0];

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_ff <= ST_CFG;
      oscCnt_ff <= '0;
      toExt_ff <= 1'b0;
    end else begin
      case (state_ff)
        ST_CFG: begin
          oscCnt_ff <= '0;
          if (cfgDone_ff) begin
            state_ff <= (wantInt || twoSpeed_ff) ? ST_INT : ST_START;
          end
        end
        ST_START: begin
          if (wakeUp) begin
            oscCnt_ff <= '0;
          end else if (modeCfg_ff == DRIVEN_CLOCK_INPUT_MODE) begin
            state_ff <= ST_EXT;
          end else if (rise[0]) begin
            oscCnt_ff <= oscCnt_ff + 1'b1;
            if (isCrystal(modeCfg_ff) &&
                oscCnt_ff == CNT_W'(STARTUP_OSC_COUNT - 1)) begin
              state_ff <= ST_EXT;
            end else if (!isCrystal(modeCfg_ff) &&
                oscCnt_ff == CNT_W'(DRIVEN_DELAY_CYCLES - 1)) begin
              state_ff <= ST_EXT;
            end
          end
        end
        ST_EXT: begin
          oscCnt_ff <= '0;
          if (wakeUp && isCrystal(modeCfg_ff)) begin
            state_ff <= ST_START;
          end else if (wantInt) begin
            toExt_ff <= 1'b0;
            state_ff <= ST_SW_OLD;
          end
        end
        ST_INT: begin
          oscCnt_ff <= '0;
          if (!wantInt) begin
            toExt_ff <= 1'b1;
            state_ff <= ST_SW_OLD;
          end
        end
        ST_SW_OLD: begin
          if (oldEdge || (!toExt_ff && failFlag_ff)) begin
            state_ff <= ST_SW_NEW;
          end
        end
        ST_SW_NEW: begin
          if (newEdge) begin
            oscCnt_ff <= oscCnt_ff + 1'b1;
          end
          if (!toExt_ff && freqSel_ff != FREQ_LF &&
              oscCnt_ff >= CNT_W'(HF_DELAY_CYCLES)) begin
            state_ff <= ST_INT;
          end else if (!toExt_ff && freqSel_ff == FREQ_LF &&
              oscCnt_ff != '0) begin
            state_ff <= ST_INT;
          end else if (toExt_ff && isCrystal(modeCfg_ff)) begin
            state_ff <= ST_START;
          end else if (toExt_ff && oscCnt_ff != '0) begin
            state_ff <= ST_EXT;
          end
        end
        default: state_ff <= ST_CFG;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      extRun_ff <= 1'b0;
    end else if (state_ff == ST_CFG) begin
      extRun_ff <= cfgDone_ff && !(twoSpeed_ff && isCrystal(modeCfg_ff))
                   && !failSafe_ff && !isInternal(modeCfg_ff);
    end else if (state_ff != ST_START) begin
      extRun_ff <= (state_ff == ST_EXT);
    end
  end

  // ----------------------------------------
  // Fail monitor
  // ----------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      failCnt_ff <= '0;
    end else if (state_ff != ST_EXT || rise[0]) begin
      failCnt_ff <= '0;
    end else if (failCnt_ff != CNT_W'(FAIL_TIMEOUT)) begin
      failCnt_ff <= failCnt_ff + 1'b1;
    end
  end
  assign failEvent = failSafe_ff && state_ff == ST_EXT &&
                     failCnt_ff == CNT_W'(FAIL_TIMEOUT - 1);

  // ----------------------------------------
  // Clock outputs and divider
  // ----------------------------------------
  logic [2:0] divCnt_ff;
  logic [2:0] divLimit;
  logic [1:0] quarter_ff;
  logic srcTick;
  logic tick;
  pin_use_s pins;
  assign pins = pinUse(modeCfg_ff);
  assign divLimit = FREQ_MAX - freqSel_ff;
  assign srcTick = (state_ff == ST_EXT) ? rise[0] :
                   (state_ff == ST_INT && freqSel_ff == FREQ_LF) ? rise[2] :
                   (state_ff == ST_INT) ? rise[1] : 1'b0;
  assign tick = srcTick && (state_ff == ST_EXT || freqSel_ff == FREQ_LF ||
                divCnt_ff == divLimit);
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      divCnt_ff <= '0;
    end else if (srcTick) begin
      divCnt_ff <= tick ? 3'h0 : divCnt_ff + 3'h1;
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      quarter_ff <= '0;
      sysClkEn <= 1'b0;
      clockOutPin <= 1'b0;
    end else begin
      sysClkEn <= tick;
      if (tick) begin
        quarter_ff <= quarter_ff + 2'h1;
      end
      clockOutPin <= pins.outQuarter & quarter_ff[1];
    end
  end
  assign execHold = (state_ff != ST_EXT && state_ff != ST_INT);
  assign clockOutOe = pins.outQuarter;
  assign clockInIsIo = pins.inIsIo;
  assign clockOutIsIo = pins.outIsIo;
  assign gainSel = (modeCfg_ff == LOW_POWER_CRYSTAL_MODE) ? GAIN_LOW :
                   (modeCfg_ff == MEDIUM_GAIN_CRYSTAL_MODE) ? GAIN_MID :
                   (modeCfg_ff == HIGH_GAIN_CRYSTAL_MODE) ? GAIN_HIGH :
                   GAIN_OFF;

  // ----------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------
  logic awHeld_ff;
  logic wHeld_ff;
  logic [3:0] awAddr_ff;
  logic [31:0] wData_ff;
  logic [3:0] wStrb_ff;
  logic doWrite;
  logic clrFail;
  assign s_axi_awready = !awHeld_ff && !s_axi_bvalid;
  assign s_axi_wready = !wHeld_ff && !s_axi_bvalid;
  assign doWrite = awHeld_ff && wHeld_ff && !s_axi_bvalid;
  assign clrFail = doWrite && awAddr_ff == IRQ_STATUS_ADDR &&
                   wStrb_ff[0] && wData_ff[FAIL_BIT];

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      awHeld_ff <= 1'b0;
      wHeld_ff <= 1'b0;
      awAddr_ff <= '0;
      wData_ff <= '0;
      wStrb_ff <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld_ff <= 1'b1;
        awAddr_ff <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld_ff <= 1'b1;
        wData_ff <= s_axi_wdata;
        wStrb_ff <= s_axi_wstrb;
      end
      if (doWrite) begin
        awHeld_ff <= 1'b0;
        wHeld_ff <= 1'b0;
        s_axi_bvalid <= 1'b1;
        if (awAddr_ff == OSC_CTRL_ADDR || awAddr_ff == IRQ_STATUS_ADDR ||
            awAddr_ff == IRQ_MASK_ADDR) begin
          s_axi_bresp <= RESP_OKAY;
        end else begin
          s_axi_bresp <= RESP_SLVERR;
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      freqSel_ff <= FREQ_RESET;
      sysSel_ff <= 1'b0;
      failMask_ff <= 1'b0;
    end else if (doWrite && wStrb_ff[0]) begin
      if (awAddr_ff == OSC_CTRL_ADDR) begin
        freqSel_ff <= wData_ff[FREQ_LSB +: 3];
        sysSel_ff <= wData_ff[SYS_SEL_BIT];
      end else if (awAddr_ff == IRQ_MASK_ADDR) begin
        failMask_ff <= wData_ff[FAIL_BIT];
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      failFlag_ff <= 1'b0;
    end else if (failEvent) begin
      failFlag_ff <= 1'b1;
    end else if (clrFail) begin
      failFlag_ff <= 1'b0;
    end
  end
  assign irq = failFlag_ff && failMask_ff;

  logic [31:0] rdMux;
  logic rdOk;
  always_comb begin
    rdMux = '0;
    rdOk = 1'b1;
    if (s_axi_araddr == OSC_CTRL_ADDR) begin
      rdMux[FREQ_LSB +: 3] = freqSel_ff;
      rdMux[EXT_RUN_BIT] = extRun_ff;
      rdMux[HF_STABLE_BIT] = hfStable_ff;
      rdMux[LF_STABLE_BIT] = lfStable_ff;
      rdMux[SYS_SEL_BIT] = sysSel_ff;
    end else if (s_axi_araddr == IRQ_STATUS_ADDR) begin
      rdMux[FAIL_BIT] = failFlag_ff;
    end else if (s_axi_araddr == IRQ_MASK_ADDR) begin
      rdMux[FAIL_BIT] = failMask_ff;
    end else begin
      rdOk = 1'b0;
    end
  end
  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rdMux;
      s_axi_rresp <= rdOk ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule : clk_source_select

// ---- inc/clk_sel_pkg.sv ----
// Package for the system clock source selector.
// Assumes a single 100 MHz clock and an AXI4-Lite register master.
package clk_sel_pkg;

  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [3:0] OSC_CTRL_ADDR = 4'h0;
  localparam logic [3:0] IRQ_STATUS_ADDR = 4'h4;
  localparam logic [3:0] IRQ_MASK_ADDR = 4'h8;

  // ----------------------------------------
  // Field layout and reset values
  // ----------------------------------------
  localparam int FREQ_LSB = 4;
  localparam int EXT_RUN_BIT = 3;
  localparam int HF_STABLE_BIT = 2;
  localparam int LF_STABLE_BIT = 1;
  localparam int SYS_SEL_BIT = 0;
  localparam int FAIL_BIT = 0;
  localparam logic [2:0] FREQ_RESET = 3'h6;
  localparam logic [2:0] FREQ_LF = 3'h0;
  localparam logic [2:0] FREQ_MAX = 3'h7;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_MHZ = 100;
  localparam int STARTUP_OSC_COUNT = 1024;
  localparam int DRIVEN_DELAY_CYCLES = 2;
  localparam int HF_DELAY_NS = 1000;
  localparam int HF_DELAY_CYCLES = (HF_DELAY_NS * CLK_MHZ + 999) / 1000;
  localparam int HF_WARM_CYCLES = 64;
  localparam int LF_WARM_CYCLES = 64;
  localparam int FAIL_TIMEOUT = 4000;
  localparam int CNT_W = 12;

  // ----------------------------------------
  // Modes and gain codes
  // ----------------------------------------
  typedef enum logic [2:0] {
    LOW_POWER_CRYSTAL_MODE = 3'b000,
    MEDIUM_GAIN_CRYSTAL_MODE = 3'b001,
    HIGH_GAIN_CRYSTAL_MODE = 3'b010,
    DRIVEN_CLOCK_INPUT_MODE = 3'b011,
    INTERNAL_OSC_ALL_PINS_IO_MODE = 3'b100,
    INTERNAL_OSC_CLOCK_OUT_MODE = 3'b101,
    RESISTOR_CAPACITOR_IO_MODE = 3'b110,
    RESISTOR_CAPACITOR_OSC_MODE = 3'b111
  } clk_mode_e;

  typedef enum logic [1:0] {
    GAIN_OFF = 2'b00,
    GAIN_LOW = 2'b01,
    GAIN_MID = 2'b10,
    GAIN_HIGH = 2'b11
  } gain_e;

  typedef struct packed {
    logic useCfg;
    logic inIsIo;
    logic outIsIo;
    logic outQuarter;
  } pin_use_s;

endpackage : clk_sel_pkg

// ---- dv/ext_osc_model.sv ----
// Far-side oscillators: external source and the two internal ones.
// Assumes a 1 ns unit; runExt low stops the external source at 0.
`timescale 1ns/1ns
module ext_osc_model #(
  parameter int EXT_HALF = 23,
  parameter int HF_HALF = 13,
  parameter int LF_HALF = 57
) (
  input wire logic runExt,
  output logic clockInPin,
  output logic hfOscIn,
  output logic lfOscIn
);
  // ----
  // Sources
  // ----
  initial begin
    clockInPin = 1'b0;
    forever begin
      #(EXT_HALF);
      clockInPin = runExt ? ~clockInPin : 1'b0;
    end
  end
  initial begin
    hfOscIn = 1'b0;
    forever #(HF_HALF) hfOscIn = ~hfOscIn;
  end
  initial begin
    lfOscIn = 1'b0;
    forever #(LF_HALF) lfOscIn = ~lfOscIn;
  end
endmodule : ext_osc_model

// ---- dv/clk_source_select_properties.sv ----
// Port checker for the clock source selector.
// Assumes config changes only while rst is high.
`timescale 1ns/1ns
module clk_source_select_properties
  import clk_sel_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [2:0] clkModeCfg,
  input wire logic twoSpeedEn,
  input wire logic wakeUp,
  input wire logic clockInPin,
  input wire logic execHold,
  input wire logic [1:0] gainSel,
  input wire logic clockOutPin,
  input wire logic clockOutOe,
  input wire logic clockInIsIo,
  input wire logic clockOutIsIo,
  input wire logic irq,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic [1:0] s_axi_rresp,
  input wire logic [31:0] s_axi_rdata
);
  // ----
  // Helpers
  // ----
  logic xtal, quart, ioOut, intMode, inPrev_ff;
  logic [10:0] edgeCnt_ff;
  assign xtal = clkModeCfg < DRIVEN_CLOCK_INPUT_MODE;
  assign quart = clkModeCfg == RESISTOR_CAPACITOR_OSC_MODE ||
    clkModeCfg == INTERNAL_OSC_CLOCK_OUT_MODE;
  assign intMode = clkModeCfg == INTERNAL_OSC_ALL_PINS_IO_MODE ||
    clkModeCfg == INTERNAL_OSC_CLOCK_OUT_MODE;
  assign ioOut = intMode && !quart || clkModeCfg ==
    DRIVEN_CLOCK_INPUT_MODE || clkModeCfg == RESISTOR_CAPACITOR_IO_MODE;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      inPrev_ff <= 1'b0;
      edgeCnt_ff <= 11'h0;
    end else begin
      inPrev_ff <= clockInPin;
      if (wakeUp)
        edgeCnt_ff <= 11'h0;
      else if (clockInPin && !inPrev_ff && edgeCnt_ff != 11'h7FF)
        edgeCnt_ff <= edgeCnt_ff + 11'h1;
    end
  end
  // ----
  // Properties
  // ----
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  a_gain_by_mode: assert property (!$past(rst) |->
    gainSel == (xtal ? clkModeCfg[1:0] + 2'h1 : 2'h0))
    else $error("gain select wrong for mode");
  a_out_pin_freed: assert property (!$past(rst) && ioOut |->
    clockOutIsIo && !clockOutOe)
    else $error("clock-out pin not freed");
  a_quarter_drive: assert property (!$past(rst) && quart |->
    clockOutOe && !clockOutIsIo)
    else $error("quarter clock pin not driven");
  a_quarter_idle: assert property (!quart |-> !clockOutPin)
    else $error("clock-out toggles outside quarter modes");
  a_in_pin_freed: assert property (!$past(rst) && intMode |->
    clockInIsIo)
    else $error("clock-in pin not freed");
  a_startup_count: assert property ($fell(execHold) && xtal &&
    !twoSpeedEn |-> edgeCnt_ff >= 11'h3FF)
    else $error("hold released before full count");
  a_driven_no_wait: assert property ($past(rst) &&
    clkModeCfg == DRIVEN_CLOCK_INPUT_MODE |-> ##[1:60] !execHold)
    else $error("driven mode start delayed");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid)
    else $error("read answer late");
  a_read_unmapped: assert property (s_axi_arvalid && s_axi_arready &&
    s_axi_araddr == 4'hC |=> s_axi_rresp == RESP_SLVERR &&
    s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  c_start_done: cover property ($fell(execHold) && xtal);
  c_fail_irq: cover property ($rose(irq));
  c_quarter_out: cover property ($rose(clockOutPin));
endmodule : clk_source_select_properties

bind clk_source_select clk_source_select_properties chk (.*);

// ---- dv/clk_source_select_test.sv ----
// Self-checking bench for the clock source selector.
// Assumes the oscillator model and the bound checker are compiled.
`timescale 1ns/1ns
`define CHK(nm, ex, ac) begin nChecks++; if ((ac) !== (ex)) begin \
  failCount++; $display("MISMATCH %s exp %0h got %0h", nm, ex, ac); end end
module clk_source_select_test import clk_sel_pkg::*;;
  logic clk = 1'b0, rst = 1'b1, twoSpeedEn = 1'b0, failSafeEn = 1'b0;
  logic wakeUp = 1'b0, runExt = 1'b1, s_axi_awvalid = 1'b0;
  logic s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic [2:0] clkModeCfg = 3'h0;
  logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
  logic clockInPin, hfOscIn, lfOscIn, sysClkEn, execHold, clockOutPin;
  logic clockOutOe, clockInIsIo, clockOutIsIo, irq, s_axi_awready;
  logic s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] gainSel, s_axi_bresp, s_axi_rresp, rsp;
  int failCount = 0;
  int nChecks = 0;

  clk_source_select dut (.*);
  ext_osc_model osc (.runExt, .clockInPin, .hfOscIn, .lfOscIn);
  initial forever #5 clk = ~clk;
  // ----
  // Bus and helper tasks
  // ----
  task automatic close_out;
    $display("checks %0d mismatches %0d", nChecks, failCount);
    if (failCount == 0 && nChecks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : close_out
  task automatic reset_to(input clk_mode_e m, input logic ts, fs);
    rst <= 1'b1;
    clkModeCfg <= m;
    twoSpeedEn <= ts;
    failSafeEn <= fs;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
  endtask : reset_to
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr
  task automatic rdr(input logic [3:0] a);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rdr
  task automatic settle(input int lim);
    int n;
    n = 0;
    repeat (2) @(posedge clk);
    while (execHold !== 1'b0 && n < lim) begin
      @(posedge clk);
      n++;
    end
    `CHK("execHold", 1'b0, execHold)
  endtask : settle
  task automatic poll(input int b);
    int n;
    n = 0;
    do begin
      rdr(OSC_CTRL_ADDR);
      n++;
    end while (!rd[b] && n < 400);
  endtask : poll
  function automatic logic [4:0] pinExp(input clk_mode_e m);
    case (m)
      LOW_POWER_CRYSTAL_MODE: return {GAIN_LOW, 3'b000};
      MEDIUM_GAIN_CRYSTAL_MODE: return {GAIN_MID, 3'b000};
      HIGH_GAIN_CRYSTAL_MODE: return {GAIN_HIGH, 3'b000};
      INTERNAL_OSC_ALL_PINS_IO_MODE: return 5'b00110;
      INTERNAL_OSC_CLOCK_OUT_MODE: return 5'b00101;
      RESISTOR_CAPACITOR_OSC_MODE: return 5'b00001;
      default: return 5'b00010;
    endcase
  endfunction : pinExp
  // ----
  // Scenarios
  // ----
  task automatic t_modes;
    int n;
    logic [4:0] got;
    for (int i = 0; i < 8; i++) begin
      reset_to(clk_mode_e'(i), 1'b0, 1'b0);
      got = {gainSel, clockInIsIo, clockOutIsIo, clockOutOe};
      `CHK("pins", pinExp(clk_mode_e'(i)), got)
    end
    settle(300);
    n = 0;
    while (clockOutPin !== 1'b1 && n < 400) begin
      @(posedge clk);
      n++;
    end
    `CHK("quarterClk", 1'b1, clockOutPin)
    $display("test modes done");
  endtask : t_modes
  task automatic t_crystal;
    reset_to(HIGH_GAIN_CRYSTAL_MODE, 1'b0, 1'b1);
    rdr(OSC_CTRL_ADDR);
    `CHK("extRunReset", 1'b0, rd[EXT_RUN_BIT])
    reset_to(MEDIUM_GAIN_CRYSTAL_MODE, 1'b1, 1'b0);
    rdr(OSC_CTRL_ADDR);
    `CHK("extRunTwoSpd", 1'b0, rd[EXT_RUN_BIT])
    reset_to(LOW_POWER_CRYSTAL_MODE, 1'b0, 1'b0);
    rdr(OSC_CTRL_ADDR);
    `CHK("extRunPlain", 1'b1, rd[EXT_RUN_BIT])
    repeat (100) @(posedge clk);
    `CHK("holdCount", 1'b1, execHold)
    settle(8000);
    rdr(OSC_CTRL_ADDR);
    `CHK("oscReset", 8'h68, rd[7:0] & 8'hF9)
    for (int c = 0; c < 8; c++) begin
      wr(OSC_CTRL_ADDR, {25'h0, c[2:0], 4'h0});
      rdr(OSC_CTRL_ADDR);
      `CHK("freq", c[2:0], rd[6:4])
    end
    wr(OSC_CTRL_ADDR, 32'h71);
    settle(2000);
    poll(HF_STABLE_BIT);
    `CHK("hfRun", 8'h75, rd[7:0] & 8'hFD)
    wr(OSC_CTRL_ADDR, 32'h01);
    settle(2000);
    poll(LF_STABLE_BIT);
    `CHK("lfRun", 8'h03, rd[7:0] & 8'hFB)
    wr(OSC_CTRL_ADDR, 32'h60);
    settle(8000);
    rdr(OSC_CTRL_ADDR);
    `CHK("backExt", 8'h68, rd[7:0] & 8'hF9)
    @(posedge clk) wakeUp <= 1'b1;
    @(posedge clk) wakeUp <= 1'b0;
    repeat (3) @(posedge clk);
    `CHK("wakeHold", 1'b1, execHold)
    settle(8000);
    $display("test crystal done");
  endtask : t_crystal
  task automatic t_static;
    int n;
    reset_to(DRIVEN_CLOCK_INPUT_MODE, 1'b0, 1'b0);
    settle(60);
    wr(OSC_CTRL_ADDR, 32'h30);
    runExt <= 1'b0;
    repeat (20) @(posedge clk);
    n = 0;
    repeat (480) begin
      @(posedge clk);
      if (sysClkEn !== 1'b0) n++;
    end
    `CHK("frozen", 0, n)
    runExt <= 1'b1;
    n = 0;
    repeat (50) begin
      @(posedge clk);
      if (sysClkEn === 1'b1) n++;
    end
    `CHK("resumed", 1'b1, n > 0)
    rdr(OSC_CTRL_ADDR);
    `CHK("static", 8'h38, rd[7:0] & 8'hF9)
    s_axi_wstrb <= 4'h0;
    wr(OSC_CTRL_ADDR, 32'h71);
    s_axi_wstrb <= 4'hF;
    rdr(OSC_CTRL_ADDR);
    `CHK("noStrb", 8'h38, rd[7:0] & 8'hF9)
    $display("test static done");
  endtask : t_static
  task automatic t_fail;
    int n;
    reset_to(DRIVEN_CLOCK_INPUT_MODE, 1'b0, 1'b1);
    settle(60);
    wr(IRQ_MASK_ADDR, 32'h1);
    runExt <= 1'b0;
    n = 0;
    while (irq !== 1'b1 && n < 5000) begin
      @(posedge clk);
      n++;
    end
    `CHK("irqFail", 1'b1, irq)
    rdr(OSC_CTRL_ADDR);
    `CHK("fallback", 1'b0, rd[EXT_RUN_BIT])
    runExt <= 1'b1;
    rdr(IRQ_STATUS_ADDR);
    `CHK("sticky", 32'h1, rd)
    wr(IRQ_MASK_ADDR, 32'h0);
    @(posedge clk);
    `CHK("masked", 1'b0, irq)
    wr(IRQ_STATUS_ADDR, 32'h1);
    wr(IRQ_MASK_ADDR, 32'h1);
    @(posedge clk);
    `CHK("cleared", 1'b0, irq)
    rdr(IRQ_STATUS_ADDR);
    `CHK("flagZero", 32'h0, rd)
    wr(4'hC, 32'hFF);
    `CHK("wrErr", RESP_SLVERR, rsp)
    rdr(4'hC);
    `CHK("rdErr", {RESP_SLVERR, 32'h0}, {rsp, rd})
    $display("test fail done");
  endtask : t_fail
  initial begin
    t_modes;
    t_crystal;
    t_static;
    t_fail;
    close_out;
  end
  initial begin
    repeat (60000) @(posedge clk);
    failCount++;
    close_out;
  end
endmodule : clk_source_select_test
